/* File: src/pofc_pkg.sv */
package pofc_pkg;
  localparam logic [11:0] TRG_OFS = 12'h000;
  localparam logic [11:0] IO_OFS = 12'h004;
  localparam logic [11:0] FCL_OFS = 12'h008;
  localparam logic [11:0] ST_OFS = 12'h00C;
  localparam logic [15:0] TRG_RST = 16'h0000;
  localparam logic [15:0] IO_RST = 16'h0000;
  localparam logic [15:0] FCL_RST = 16'h0000;
  localparam logic [15:0] TRG_WMASK = 16'hF0BF;
  localparam logic [15:0] FCL_WMASK = 16'hFFFF;
  localparam int TRG_DTM_BIT = 7;
  localparam int IO_PEN_H = 15;
  localparam int IO_PEN_L = 14;
  localparam int IO_POL_H = 13;
  localparam int IO_POL_L = 12;
  localparam int IO_OVR_H = 9;
  localparam int IO_OVR_L = 8;
  localparam int IO_SWAP = 1;
  localparam int IO_OVERRIDE_SYNC = 0;
  localparam int FCL_IND = 15;
  localparam int FCL_LIMIT_SOURCE_POLARITY = 9;
  localparam int FCL_CLEN = 8;
  localparam int FCL_FPOL = 2;
  localparam logic [4:0] SRC_LAST = 5'h07;
  localparam logic [1:0] FM_LATCH = 2'h0;
  localparam logic [1:0] FM_CYCLE = 2'h1;
  localparam logic [1:0] FM_OFF = 2'h3;
  typedef enum logic [1:0]
  {
    PM_COMP = 2'b00,
    PM_REDUN = 2'b01,
    PM_PUSH = 2'b10,
    PM_INDEP = 2'b11
  } pofc_pmode_t;
  typedef struct packed
  {
    logic high;
    logic low;
  } pofc_pair_t;
endpackage : pofc_pkg

/* File: src/pofc_src_sel.sv */
`timescale 1ns/10ps
module pofc_src_sel
(
  input wire logic [7:0] fault_in,
  input wire logic [4:0] sel,
  input wire logic active_low,
  input wire logic enable,
  output logic active
);
  logic raw;
  always_comb
  begin
    raw = 1'b0;
    if (sel <= pofc_pkg::SRC_LAST)
    begin
      raw = fault_in[sel[2:0]];
    end
    active = enable & (raw ^ active_low);
  end
endmodule : pofc_src_sel

/* File: src/pofc_trig.sv */
`timescale 1ns/10ps
module pofc_trig
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic cycle_start,
  input wire logic pri_event,
  input wire logic sec_event,
  input wire logic merge,
  input wire logic [5:0] start_delay,
  output logic trig_q,
  output logic sec_trig_q,
  output logic trig_irq_q
);
  logic [5:0] wait_q;
  logic armed_q;
  logic en_q;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_q <= 6'h00;
      armed_q <= 1'b0;
      en_q <= 1'b0;
    end
    else
    begin
      en_q <= enable;
      if (!enable)
      begin
        armed_q <= 1'b0;
      end
      else if (!en_q)
      begin
        wait_q <= start_delay;
        armed_q <= (start_delay == 6'h00);
      end
      else if (!armed_q && cycle_start)
      begin
        if (wait_q <= 6'h01)
        begin
          armed_q <= 1'b1;
        end
        wait_q <= wait_q - 6'h01;
      end
    end
  end
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      trig_q <= 1'b0;
      sec_trig_q <= 1'b0;
      trig_irq_q <= 1'b0;
    end
    else
    begin
      trig_q <= armed_q & (pri_event | (merge & sec_event));
      sec_trig_q <= armed_q & ~merge & sec_event;
      trig_irq_q <= armed_q & pri_event;
    end
  end
endmodule : pofc_trig

/* File: src/pofc_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - dual trigger merge folds secondary event into the one primary trigger
// - first trigger waits start_delay PWM cycles, 0 to 63, after enable
// - secondary trigger never raises the trigger interrupt
// - ownership bit 1 gives pin to PWM, 0 to general I/O
// - polarity bit 1 makes pin active-low, 0 active-high
// - pair mode 00 complementary, 01 redundant, 10 push-pull, 11 independent
// - override enable replaces generator with override_value bit per pin
// - normal mode fault forces high and low to fault_state_value bits
// - independent mode: limit forces high, fault forces low, limit states unused
// - normal mode current-limit forces pins to limit_state_value bits
// - swap bit exchanges high and low generator signals between pins
// - override_sync 1 aligns override value change to PWM time base, else next clock; the override enables act directly
// - limit source codes 0..7 pick fault input 1..8, higher reserved
// - limit polarity 1 treats source as active-low
// - current-limit acts only while its enable bit is 1
// - fault mode 00 latched, 01 per cycle, 10 reserved, 11 disabled
// - fault source codes 0..7 pick input 1..8, polarity 1 active-low
module pofc_top
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic time_base_enable,
  input wire logic cycle_start,
  input wire logic gen_high,
  input wire logic gen_low,
  input wire logic pri_event,
  input wire logic sec_event,
  input wire logic [7:0] fault_pins,
  output logic high_output_pin,
  output logic low_output_pin,
  output logic high_pin_own,
  output logic low_pin_own,
  output logic trig_q,
  output logic sec_trig_q,
  output logic trig_irq_q
);
  logic [15:0] trg_q;
  logic [15:0] io_q;
  logic [15:0] fcl_q;
  logic [7:0] fsync1_q;
  logic [7:0] fsync2_q;
  logic [1:0] ovr_live_q;
  logic fault_latch_q;
  logic fault_act;
  logic limit_act;
  logic fault_hit;
  logic fault_eff;
  logic wr_en;
  logic rd_hit;
  logic [15:0] rd_val;
  pofc_pkg::pofc_pair_t gen;
  pofc_pkg::pofc_pair_t active_lvl;
  pofc_pkg::pofc_pair_t pins_d;
  pofc_pkg::pofc_pmode_t pmode;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == pofc_pkg::TRG_OFS) || (a == pofc_pkg::IO_OFS) ||
      (a == pofc_pkg::FCL_OFS) || (a == pofc_pkg::ST_OFS);
  endfunction : addr_known

  // fault mode decode shared by the enable, the latch and the forcing logic
  function automatic logic fault_mode_is(input logic [15:0] r, input logic [1:0] m);
    fault_mode_is = (r[1:0] == m);
  endfunction : fault_mode_is

  // zero-wait slave: answer in the access phase itself
  assign wr_en = psel & penable & pwrite & addr_known(paddr);
  assign rd_hit = addr_known(paddr);

  // one process per register keeps each write decode on its own
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      trg_q <= pofc_pkg::TRG_RST;
    end
    else if (wr_en && paddr == pofc_pkg::TRG_OFS)
    begin
      trg_q <= pwdata[15:0] & pofc_pkg::TRG_WMASK;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      io_q <= pofc_pkg::IO_RST;
    end
    else if (wr_en && paddr == pofc_pkg::IO_OFS)
    begin
      io_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fcl_q <= pofc_pkg::FCL_RST;
    end
    else if (wr_en && paddr == pofc_pkg::FCL_OFS)
    begin
      fcl_q <= pwdata[15:0] & pofc_pkg::FCL_WMASK;
    end
  end

  always_comb
  begin
    rd_val = 16'h0000;
    case (paddr)
      pofc_pkg::TRG_OFS: rd_val = trg_q;
      pofc_pkg::IO_OFS: rd_val = io_q;
      pofc_pkg::FCL_OFS: rd_val = fcl_q;
      pofc_pkg::ST_OFS: rd_val = {11'h000, fault_latch_q, fault_act, limit_act,
        high_output_pin, low_output_pin};
      default: rd_val = 16'h0000;
    endcase
  end

  // answer comes in the first access cycle, never later
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
    end
  end

  // read data captured in setup so it stands through the access cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel & ~penable & ~pwrite)
    begin
      prdata <= {16'h0000, rd_val};
    end
  end

  // fault pins are asynchronous to mclk
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fsync1_q <= 8'h00;
      fsync2_q <= 8'h00;
    end
    else
    begin
      fsync1_q <= fault_pins;
      fsync2_q <= fsync1_q;
    end
  end

  pofc_src_sel u_fault_sel
  (
    .fault_in(fsync2_q),
    .sel(fcl_q[7:3]),
    .active_low(fcl_q[pofc_pkg::FCL_FPOL]),
    .enable(!fault_mode_is(fcl_q, pofc_pkg::FM_OFF)),
    .active(fault_hit)
  );

  pofc_src_sel u_limit_sel
  (
    .fault_in(fsync2_q),
    .sel(fcl_q[14:10]),
    .active_low(fcl_q[pofc_pkg::FCL_LIMIT_SOURCE_POLARITY]),
    .enable(fcl_q[pofc_pkg::FCL_CLEN]),
    .active(limit_act)
  );

  // latched mode holds until a cycle start sees the source gone
  // set beats clear so a fault seen at a cycle start stays latched
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fault_latch_q <= 1'b0;
    end
    else if (fault_hit && fault_mode_is(fcl_q, pofc_pkg::FM_LATCH))
    begin
      fault_latch_q <= 1'b1;
    end
    else if (fault_mode_is(fcl_q, pofc_pkg::FM_OFF) || cycle_start)
    begin
      fault_latch_q <= 1'b0;
    end
  end

  // reserved mode 10 acts like per-cycle
  assign fault_act = fault_mode_is(fcl_q, pofc_pkg::FM_LATCH) ? (fault_hit | fault_latch_q)
    : fault_hit;

  // override values take effect here, synced to time base if asked; the enables act directly
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ovr_live_q <= 2'b00;
    end
    else if (!io_q[pofc_pkg::IO_OVERRIDE_SYNC] || cycle_start)
    begin
      ovr_live_q <= io_q[7:6];
    end
  end

  assign pmode = pofc_pkg::pofc_pmode_t'(io_q[11:10]);
  assign fault_eff = fault_act;

  always_comb
  begin
    // shape generator pair by mode
    case (pmode)
      pofc_pkg::PM_COMP:
      begin
        gen.high = gen_high;
        gen.low = ~gen_high;
      end
      pofc_pkg::PM_REDUN:
      begin
        gen.high = gen_high;
        gen.low = gen_high;
      end
      pofc_pkg::PM_PUSH:
      begin
        gen.high = gen_high;
        gen.low = gen_low;
      end
      pofc_pkg::PM_INDEP:
      begin
        gen.high = gen_high;
        gen.low = gen_low;
      end
      default:
      begin
        gen.high = gen_high;
        gen.low = ~gen_high;
      end
    endcase
    active_lvl.high = io_q[pofc_pkg::IO_SWAP] ? gen.low : gen.high;
    active_lvl.low = io_q[pofc_pkg::IO_SWAP] ? gen.high : gen.low;
    if (io_q[pofc_pkg::IO_OVR_H])
    begin
      active_lvl.high = ovr_live_q[1];
    end
    if (io_q[pofc_pkg::IO_OVR_L])
    begin
      active_lvl.low = ovr_live_q[0];
    end
    if (fcl_q[pofc_pkg::FCL_IND])
    begin
      if (limit_act)
      begin
        active_lvl.high = io_q[5];
      end
      if (fault_eff)
      begin
        active_lvl.low = io_q[4];
      end
    end
    else
    begin
      if (limit_act)
      begin
        active_lvl.high = io_q[3];
        active_lvl.low = io_q[2];
      end
      if (fault_eff)
      begin
        active_lvl.high = io_q[5];
        active_lvl.low = io_q[4];
      end
    end
    pins_d.high = active_lvl.high ^ io_q[pofc_pkg::IO_POL_H];
    pins_d.low = active_lvl.low ^ io_q[pofc_pkg::IO_POL_L];
  end

  // pins follow the datapath one clock later, so no glitch reaches the stage
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_output_pin <= 1'b0;
      low_output_pin <= 1'b0;
    end
    else
    begin
      high_output_pin <= pins_d.high;
      low_output_pin <= pins_d.low;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_pin_own <= 1'b0;
      low_pin_own <= 1'b0;
    end
    else
    begin
      high_pin_own <= io_q[pofc_pkg::IO_PEN_H];
      low_pin_own <= io_q[pofc_pkg::IO_PEN_L];
    end
  end

  pofc_trig u_trig
  (
    .mclk(mclk),
    .resetn(resetn),
    .enable(time_base_enable),
    .cycle_start(cycle_start),
    .pri_event(pri_event),
    .sec_event(sec_event),
    .merge(trg_q[pofc_pkg::TRG_DTM_BIT]),
    .start_delay(trg_q[5:0]),
    .trig_q(trig_q),
    .sec_trig_q(sec_trig_q),
    .trig_irq_q(trig_irq_q)
  );
endmodule : pofc_top

/* File: verification/pofc_monitor.sv */
`timescale 1ns/10ps
module pofc_monitor
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic time_base_enable,
  input wire logic [7:0] fault_pins,
  input wire logic high_output_pin,
  input wire logic low_output_pin,
  input wire logic high_pin_own,
  input wire logic low_pin_own,
  input wire logic trig_q
);
  logic [15:0] io_q;
  logic [15:0] fcl_q;
  logic [7:0] fp_q;
  wire wr = psel && penable && pready && pwrite;
  // pin checks wait for five quiet cycles so the input sync has settled
  wire quiet = !wr && fault_pins == fp_q && io_q[15:14] == 2'h3 && !io_q[0];
  wire f_act = fcl_q[7:3] <= 5'h07 && fcl_q[1:0] != 2'h3 && fault_pins[fcl_q[5:3]] ^ fcl_q[2];
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge mclk)
    fp_q <= fault_pins;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      {io_q, fcl_q} <= 32'h00000000;
    else if (wr && paddr == pofc_pkg::IO_OFS)
      io_q <= pwdata[15:0];
    else if (wr && paddr == pofc_pkg::FCL_OFS)
      fcl_q <= pwdata[15:0];
  end
  a_ready_next:
    assert property (psel && !penable |=> pready) else $error("pready late");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready:
    assert property (pslverr |-> pready) else $error("stray pslverr");
  a_unmapped_err:
    assert property (psel && !penable && paddr > 12'h00C |=> pslverr) else $error("no pslverr");
  a_own_follow:
    assert property (wr && paddr == pofc_pkg::IO_OFS |->
      ##2 {high_pin_own, low_pin_own} == io_q[15:14]) else $error("own lag");
  a_override_pins:
    assert property ((quiet && !f_act && !fcl_q[8] && io_q[9:8] == 2'h3)[*5] |->
      high_output_pin == (io_q[7] ^ io_q[13]) && low_output_pin == (io_q[6] ^ io_q[12]))
      else $error("override pins");
  a_fault_pins:
    assert property ((quiet && f_act && !fcl_q[15])[*5] |->
      high_output_pin == (io_q[5] ^ io_q[13]) && low_output_pin == (io_q[4] ^ io_q[12]))
      else $error("fault pins");
  a_idle_trig:
    assert property (!time_base_enable[*2] |-> !trig_q) else $error("trigger while off");
endmodule : pofc_monitor
bind pofc_top pofc_monitor mon_u (.*);

/* File: verification/pofc_stage.sv */
`timescale 1ns/10ps
// power stage: its sensors come back as level fault inputs
module pofc_stage
(
  input wire logic mclk,
  input wire logic high_output_pin,
  input wire logic low_output_pin,
  input wire logic [7:0] trip,
  output logic [7:0] fault_pins,
  output pofc_pkg::pofc_pair_t seen_q
);
  assign fault_pins = trip;
  always_ff @(posedge mclk)
    seen_q <= '{high: high_output_pin, low: low_output_pin};
endmodule : pofc_stage

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  typedef struct packed
  {
    logic [15:0] io;
    logic [15:0] fcl;
    logic [7:0] fin;
    logic [1:0] pins;
  } pofc_row_t;
  pofc_row_t rows [12] = '{
    '{16'hC380, 16'h0003, 8'h01, 2'h2},
    '{16'hF780, 16'h0003, 8'h00, 2'h1},
    '{16'hCB60, 16'h0001, 8'h01, 2'h2},
    '{16'hC760, 16'h003D, 8'h7F, 2'h2},
    '{16'hC384, 16'h0903, 8'h04, 2'h1},
    '{16'hC384, 16'h0803, 8'h04, 2'h2},
    '{16'hC384, 16'h0B03, 8'hFB, 2'h1},
    '{16'hC384, 16'h2103, 8'hFF, 2'h2},
    '{16'hC3CC, 16'h8511, 8'h02, 2'h1},
    '{16'hC3CC, 16'h8511, 8'h04, 2'h2},
    '{16'hCC02, 16'h0003, 8'h00, 2'h1},
    '{16'hC400, 16'h0003, 8'h00, 2'h3}
  };
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic time_base_enable = 1'b0;
  logic cycle_start = 1'b0;
  logic pri_event = 1'b0;
  logic sec_event = 1'b0;
  // generator levels stay fixed: its timing lies outside this block
  logic gen_high = 1'b1;
  logic gen_low = 1'b0;
  logic [7:0] trip = 8'h00;
  logic [31:0] prdata;
  logic [7:0] fault_pins;
  logic pready, pslverr, high_output_pin, low_output_pin, high_pin_own, low_pin_own;
  logic trig_q, sec_trig_q, trig_irq_q, er;
  logic [31:0] rd;
  logic [2:0] acc;
  pofc_pkg::pofc_pair_t seen_q;
  int failures = 0;
  int cmp_count = 0;
  pofc_top dut_u (.*);
  pofc_stage stage_u (.*);
  task automatic ck(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask : ck
  task automatic xfer(input logic [11:0] a, input logic w, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : xfer
  task automatic ev(input logic [2:0] e, input logic [2:0] x);
    {pri_event, sec_event, cycle_start} <= e;
    @(posedge mclk);
    {pri_event, sec_event, cycle_start} <= 3'h0;
    acc = 3'h0;
    repeat (4)
    begin
      @(posedge mclk);
      acc = acc | {trig_q, sec_trig_q, trig_irq_q};
    end
    ck("trig", 32'(x), 32'(acc));
  endtask : ev
  task automatic close_out();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    #400000;
    failures++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    foreach (rows[i])
    begin
      xfer(pofc_pkg::IO_OFS, 1'b1, rows[i].io);
      xfer(pofc_pkg::FCL_OFS, 1'b1, rows[i].fcl);
      trip <= rows[i].fin;
      repeat (6) @(posedge mclk);
      ck("pin", 32'(rows[i].pins), 32'(seen_q));
      xfer(pofc_pkg::IO_OFS, 1'b0, 16'h0000);
      ck("io", {16'h0000, rows[i].io}, rd);
    end
    xfer(pofc_pkg::IO_OFS, 1'b1, 16'hC380);
    xfer(pofc_pkg::IO_OFS, 1'b1, 16'hC341);
    repeat (6) @(posedge mclk);
    ck("hold", 32'h2, 32'(seen_q));
    ev(3'h1, 3'h0);
    ck("sync", 32'h1, 32'(seen_q));
    xfer(pofc_pkg::IO_OFS, 1'b1, 16'hC030);
    xfer(pofc_pkg::FCL_OFS, 1'b1, 16'h0000);
    trip <= 8'h01;
    repeat (6) @(posedge mclk);
    ck("latch", 32'h3, 32'(seen_q));
    trip <= 8'h00;
    repeat (6) @(posedge mclk);
    ck("held", 32'h3, 32'(seen_q));
    xfer(pofc_pkg::ST_OFS, 1'b0, 16'h0000);
    ck("status", 32'h0000_001B, rd);
    ev(3'h1, 3'h0);
    ck("clear", 32'h2, 32'(seen_q));
    xfer(pofc_pkg::TRG_OFS, 1'b1, 16'h0002);
    time_base_enable <= 1'b1;
    ev(3'h4, 3'h0);
    ev(3'h1, 3'h0);
    ev(3'h1, 3'h0);
    ev(3'h4, 3'h5);
    ev(3'h2, 3'h2);
    xfer(pofc_pkg::TRG_OFS, 1'b1, 16'h0082);
    ev(3'h2, 3'h4);
    resetn <= 1'b0;
    time_base_enable <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    ck("own", 32'h0, 32'({high_pin_own, low_pin_own}));
    for (int k = 0; k < 3; k++)
    begin
      xfer(12'(4 * k), 1'b0, 16'h0000);
      ck("reset", 32'h0, rd);
    end
    xfer(12'h010, 1'b0, 16'h0000);
    ck("err", 32'h1, 32'(er));
    ck("gap", 32'h0, rd);
    close_out();
  end
endmodule : testbench
